// >>> rtl/ttmr_ahb_port.sv
// AHB-Lite transfer decode for the tick timer registers
`timescale 1ns/1ns
`default_nettype none
`include "ttmr_regs.svh"

module ttmr_ahb_port (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Address phase
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hready,
	input wire logic [11:0] haddrLow,
	// Decoded accesses
	output logic rdReq,
	output logic wrStb,
	output logic [11:0] wrAddr
);

	logic wrPend_r;
	logic [11:0] wrAddr_r;

	// ------------------------------------
	// Address phase decode
	// ------------------------------------
	// Sub-word writes are dropped: the registers hold whole words only
	wire accept = hsel && htrans[1] && hready;
	wire wrAccept = accept && hwrite && (hsize == `TTMR_HSIZE_WORD);

	assign rdReq = accept && !hwrite;
	assign wrStb = wrPend_r;
	assign wrAddr = wrAddr_r;

	// ------------------------------------
	// Data phase of a write
	// ------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			wrPend_r <= 1'h0;
			wrAddr_r <= 12'h000;
		end else if (hready) begin
			wrPend_r <= wrAccept;
			wrAddr_r <= haddrLow;
		end
	end

endmodule : ttmr_ahb_port

`default_nettype wire

// >>> rtl/ttmr_pkg.sv
// Types shared by the tick timer modules
package ttmr_pkg;

	typedef enum logic [1:0] {
		MODE_DISABLED = 2'h0,
		MODE_CONTINUE_ON_MATCH = 2'h1,
		MODE_RESTART_ON_MATCH = 2'h2,
		MODE_SINGLE_SHOT = 2'h3
	} ttmr_mode_type;

	typedef logic [27:0] ttmr_count_type;

endpackage : ttmr_pkg

// >>> rtl/ttmr_regs.svh
// Register offsets, field positions, reset values of the tick timer
`ifndef TTMR_REGS_SVH
`define TTMR_REGS_SVH

// --------------------------------------------
// Register byte offsets
// --------------------------------------------
`define TTMR_OFF_CTRL 12'h000
`define TTMR_OFF_REF 12'h004
`define TTMR_OFF_COUNT 12'h008
`define TTMR_OFF_STAT 12'h00C

// --------------------------------------------
// Field positions
// --------------------------------------------
`define TTMR_CTRL_MODE_LSB 0
`define TTMR_CTRL_MODE_MSB 1
`define TTMR_CTRL_IRQEN_BIT 2
`define TTMR_STAT_PEND_BIT 0
`define TTMR_STAT_HALT_BIT 1
`define TTMR_CNT_MSB 27

// --------------------------------------------
// Reset values and bus constants
// --------------------------------------------
`define TTMR_RST_COUNT 28'h0000000
`define TTMR_RST_REF 28'h0000000
`define TTMR_RST_IRQEN 1'h0
`define TTMR_HSIZE_WORD 3'h2

`endif

// >>> rtl/ttmr_timer.sv
// Tick timer core: counter, reference match, modes and AHB registers
`timescale 1ns/1ns
`default_nettype none
`include "ttmr_regs.svh"

// Contract
// RULE1 - The counter counts up, is compared with the reference, and on a match continues, restarts from zero or halts as the mode selects.
// RULE2 - The mode field offers continue, restart, single-shot and disabled, and any of the first three enables the timer.
// RULE3 - A counting mode starts counting at once from the counter's present value without clearing it.
// RULE4 - After reset the timer is disabled and does not count until software picks a counting mode.
// RULE5 - The reference is a 28-bit software-written value compared with the running count.
// RULE6 - A write of the count loads the counter, and an enabled timer counts on from that value at once.
// RULE7 - Writing zero to the count clears the counter whatever the mode or enable state.
// RULE8 - A single-shot timer halted on a match resumes when software loads a new count, without reselecting the mode.
// RULE9 - Software can read the present counter value at any time.
// RULE10 - With the interrupt enable set, every match of count and reference raises the interrupt.
// RULE11 - A readable pending flag is true while a match interrupt is outstanding and false otherwise.
// RULE12 - A match interrupt serves as a wake request that brings the processor out of doze.
// RULE13 - The timer runs on the peripheral clock.
// RULE14 - Software should disable the timer, load the count, set the reference and then pick the mode, in that order.
// RULE15 - Software has an action that clears an outstanding match pending flag.
// RULE16 - In continue mode the counter wraps from all ones to zero and keeps counting.
// RULE17 - The interrupt output is high while the pending flag and the interrupt enable are both set.
module ttmr_timer (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Timer events
	output logic tickIrq,
	output logic dozeWake
);

	import ttmr_pkg::*;

	// --------------------------------------------
	// State
	// --------------------------------------------
	ttmr_mode_type mode_r;
	ttmr_mode_type mode_nxt;
	logic irqEn_r;
	logic irqEn_nxt;
	ttmr_count_type ref_r;
	ttmr_count_type ref_nxt;
	ttmr_count_type count_r;
	ttmr_count_type count_nxt;
	logic halt_r;
	logic halt_nxt;
	logic pend_r;
	logic pend_nxt;
	logic irq_r;
	logic wake_r;
	logic hreadyout_r;
	logic hresp_r;
	logic [31:0] hrdata_r;
	logic [31:0] rdData;
	logic rdReq;
	logic wrStb;
	logic [11:0] wrAddr;

	// --------------------------------------------
	// Bus decode
	// --------------------------------------------
	ttmr_ahb_port u_port (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.hsel(hsel),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hready(hready),
		.haddrLow(haddr[11:0]),
		.rdReq(rdReq),
		.wrStb(wrStb),
		.wrAddr(wrAddr)
	);

	wire wrCtrl = wrStb && (wrAddr == `TTMR_OFF_CTRL);
	wire wrRef = wrStb && (wrAddr == `TTMR_OFF_REF);
	wire wrCount = wrStb && (wrAddr == `TTMR_OFF_COUNT);
	wire wrStat = wrStb && (wrAddr == `TTMR_OFF_STAT);
	wire [27:0] loadVal = hwdata[`TTMR_CNT_MSB:0];
	wire clrPend = wrStat && hwdata[`TTMR_STAT_PEND_BIT];
	wire [1:0] modeField =
		hwdata[`TTMR_CTRL_MODE_MSB:`TTMR_CTRL_MODE_LSB];

	// --------------------------------------------
	// Counting and match
	// --------------------------------------------
	// Any mode but disabled enables the timer [RULE2]
	wire running = (mode_r != MODE_DISABLED) && !halt_r;
	// Only a running timer matches, so a halted one never refires
	wire match = running && (count_r == ref_r); // [RULE1] [RULE5]
	wire isRestart = mode_r == MODE_RESTART_ON_MATCH;
	wire isSingle = mode_r == MODE_SINGLE_SHOT;
	// Plain 28-bit add rolls over to zero from all ones [RULE16]
	wire [27:0] countInc = count_r + 28'h0000001;

	// A load beats the match action, zero included [RULE6] [RULE7]
	assign count_nxt =
		wrCount ? loadVal :
		(match && isRestart) ? 28'h0000000 :
		(match && isSingle) ? count_r :
		running ? countInc : // [RULE3] [RULE13]
		count_r;

	// Single shot halts; a new count or a mode write re-arms [RULE8]
	assign halt_nxt =
		(wrCount || wrCtrl) ? 1'h0 :
		(match && isSingle) ? 1'h1 :
		halt_r;

	assign mode_nxt = wrCtrl ? ttmr_mode_type'(modeField) : mode_r;
	assign irqEn_nxt = wrCtrl ? hwdata[`TTMR_CTRL_IRQEN_BIT] : irqEn_r;
	assign ref_nxt = wrRef ? loadVal : ref_r; // [RULE5]

	// A match in the clearing cycle keeps the flag set [RULE11] [RULE15]
	assign pend_nxt = match || (pend_r && !clrPend);

	// --------------------------------------------
	// Register read mux
	// --------------------------------------------
	// Unmapped offsets read as zero with an OKAY answer
	wire [11:0] rdAddr = haddr[11:0];
	always_comb begin
		rdData = 32'h00000000;
		case (rdAddr)
			`TTMR_OFF_CTRL: begin
				rdData[`TTMR_CTRL_MODE_MSB:`TTMR_CTRL_MODE_LSB] = mode_r;
				rdData[`TTMR_CTRL_IRQEN_BIT] = irqEn_r;
			end
			`TTMR_OFF_REF: begin
				rdData[`TTMR_CNT_MSB:0] = ref_r;
			end
			`TTMR_OFF_COUNT: begin
				rdData[`TTMR_CNT_MSB:0] = count_r; // [RULE9]
			end
			`TTMR_OFF_STAT: begin
				rdData[`TTMR_STAT_PEND_BIT] = pend_r; // [RULE11]
				rdData[`TTMR_STAT_HALT_BIT] = halt_r;
			end
			default: begin
				rdData = 32'h00000000;
			end
		endcase
	end

	// --------------------------------------------
	// Timer registers
	// --------------------------------------------
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mode_r <= MODE_DISABLED; // [RULE4]
			irqEn_r <= `TTMR_RST_IRQEN;
			ref_r <= `TTMR_RST_REF;
			count_r <= `TTMR_RST_COUNT;
			halt_r <= 1'h0;
			pend_r <= 1'h0;
		end else begin
			mode_r <= mode_nxt;
			irqEn_r <= irqEn_nxt;
			ref_r <= ref_nxt;
			count_r <= count_nxt;
			halt_r <= halt_nxt;
			pend_r <= pend_nxt;
		end
	end

	// --------------------------------------------
	// Interrupt and wake
	// --------------------------------------------
	// Doze wake shares the gated flag so both drop on a clear
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			irq_r <= 1'h0;
			wake_r <= 1'h0;
		end else begin
			irq_r <= pend_r && irqEn_r; // [RULE10] [RULE17]
			wake_r <= pend_r && irqEn_r; // [RULE12]
		end
	end

	// --------------------------------------------
	// Bus answer
	// --------------------------------------------
	// Zero wait states: read data are latched in the address phase
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hreadyout_r <= 1'h0;
			hresp_r <= 1'h0;
			hrdata_r <= 32'h00000000;
		end else begin
			hreadyout_r <= 1'h1;
			hresp_r <= 1'h0;
			if (rdReq) begin
				hrdata_r <= rdData;
			end
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp = hresp_r;
	assign hrdata = hrdata_r;
	assign tickIrq = irq_r;
	assign dozeWake = wake_r;

	// --------------------------------------------
	// Checks
	// --------------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_b);

	sequence runFree;
		running && !match && !wrCount;
	endsequence

	sequence singleHit;
		match && isSingle && !wrCount && !wrCtrl;
	endsequence

	sequence stayHalted;
		halt_r && !wrCount && !wrCtrl;
	endsequence

	sequence armTimer;
		wrCtrl && (modeField != 2'h0) && !running && !wrCount;
	endsequence

	chk_disabled_hold: assert property ( // [RULE4]
		(mode_r == MODE_DISABLED) && !wrCount
		|=> count_r == $past(count_r))
		else $error("disabled timer changed its count");

	chk_count_step: assert property ( // [RULE1]
		runFree |=> count_r == $past(countInc))
		else $error("running count did not step by one");

	chk_restart_zero: assert property ( // [RULE1]
		match && isRestart && !wrCount |=> count_r == 28'h0000000)
		else $error("restart mode did not return to zero");

	chk_single_halt: assert property ( // [RULE1]
		singleHit ##1 stayHalted |=> count_r == $past(count_r, 2)
		&& halt_r)
		else $error("single shot did not hold after match");

	chk_load_value: assert property ( // [RULE6]
		wrCount |=> count_r == $past(loadVal))
		else $error("count write did not load the counter");

	chk_resume_load: assert property ( // [RULE8]
		halt_r && wrCount && isSingle |=> !halt_r ##1
		(count_r != $past(count_r) ||
		$past(match || wrCount || wrCtrl)))
		else $error("single shot did not resume after load");

	chk_pend_set: assert property ( // [RULE11]
		match |=> pend_r ##1 (pend_r || $past(clrPend)))
		else $error("match did not set the pending flag");

	chk_irq_follow: assert property ( // [RULE17]
		pend_r && irqEn_r |=> tickIrq && dozeWake)
		else $error("enabled pending flag did not raise irq");

	chk_irq_quiet: assert property ( // [RULE17]
		!irqEn_r && !wrCtrl |=> !tickIrq)
		else $error("irq raised while disabled");

	chk_read_count: assert property ( // [RULE9]
		rdReq && (rdAddr == `TTMR_OFF_COUNT)
		|=> hrdata[`TTMR_CNT_MSB:0] == $past(count_r))
		else $error("count read returned a stale value");

	chk_wrap_zero: assert property ( // [RULE16]
		runFree and (count_r == 28'hFFFFFFF) |=> count_r == 28'h0000000)
		else $error("counter did not wrap to zero");

	chk_arm_start: assert property ( // [RULE3]
		armTimer |=> count_r == $past(count_r) ##1
		(count_r == $past(countInc) ||
		$past(match || wrCount || wrCtrl)))
		else $error("enabled timer did not count from its value");

	chk_mode_write: assert property ( // [RULE2]
		wrCtrl |=> mode_r == $past(modeField))
		else $error("mode write did not land");

	chk_ref_write: assert property ( // [RULE5]
		wrRef |=> ref_r == $past(loadVal))
		else $error("reference write did not land");

	chk_ref_hold: assert property ( // [RULE5]
		!wrRef |=> ref_r == $past(ref_r))
		else $error("reference changed without a write");

	chk_load_zero: assert property ( // [RULE7]
		wrCount && (loadVal == 28'h0000000) |=> count_r == 28'h0000000)
		else $error("zero write did not clear the counter");

	chk_halt_rearm: assert property ( // [RULE8]
		(wrCount || wrCtrl) |=> !halt_r)
		else $error("write did not re-arm the single shot");

	chk_pend_hold: assert property ( // [RULE11]
		pend_r && !clrPend |=> pend_r)
		else $error("pending flag dropped without a clear");

	chk_pend_clear: assert property ( // [RULE15]
		clrPend && !match |=> !pend_r)
		else $error("pending clear did not take");

	chk_pend_quiet: assert property ( // [RULE11]
		!pend_r && !match |=> !pend_r)
		else $error("pending flag set without a match");

	chk_irq_enable: assert property ( // [RULE10]
		match && irqEn_r && !wrCtrl |=> ##1 tickIrq)
		else $error("enabled match raised no irq");

	chk_irq_drop: assert property ( // [RULE17]
		!pend_r |=> !tickIrq)
		else $error("irq raised with no pending flag");

	chk_wake_drop: assert property ( // [RULE12]
		!(pend_r && irqEn_r) |=> !dozeWake)
		else $error("doze wake raised with no enabled match");

	chk_read_stat: assert property ( // [RULE11]
		rdReq && (rdAddr == `TTMR_OFF_STAT)
		|=> hrdata[`TTMR_STAT_PEND_BIT] == $past(pend_r))
		else $error("status read returned a stale flag");

endmodule : ttmr_timer

`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the tick timer over its AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "ttmr_regs.svh"

module tb;
	import ttmr_pkg::*;
	// ----
	// Bench signals
	// ----
	logic clk_sys;
	logic rst_b;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic tickIrq;
	logic dozeWake;
	logic rdPhase;
	logic [31:0] expQ[$];
	int num_errors;
	int compares;
	int seedVal;
	logic [27:0] s;
	logic [27:0] r;

	ttmr_timer ttmr_timer_inst (
		.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .tickIrq(tickIrq), .dozeWake(dozeWake)
	);

	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end

	// ----
	// Compare, bus and model tasks
	// ----
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check

	task automatic check_bit(input logic got, input logic exp);
		check({31'h0, got}, {31'h0, exp});
	endtask : check_bit

	// Address phase held until hready, then data phase held until hready
	task automatic bus(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [2:0] sz);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {20'h00000, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= sz;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdPhase <= ~wr;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rdPhase <= 1'b0;
	endtask : bus

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		bus(1'b1, a, d, `TTMR_HSIZE_WORD);
	endtask : wr

	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		expQ.push_back(e);
		bus(1'b0, a, 32'h00000000, `TTMR_HSIZE_WORD);
	endtask : rd

	// Count, pending and halted after n enabled edges
	task automatic model(input ttmr_mode_type m, input logic [27:0] st,
		input logic [27:0] rf, input int n, output logic [27:0] c,
		output logic p, output logic h);
		c = st;
		p = 1'b0;
		h = 1'b0;
		repeat (n) begin
			if (!h && c == rf) begin
				p = 1'b1;
				if (m == MODE_RESTART_ON_MATCH) c = 28'h0000000;
				else if (m == MODE_SINGLE_SHOT) h = 1'b1;
				else c = c + 28'h0000001;
			end else if (!h) begin
				c = c + 28'h0000001;
			end
		end
	endtask : model

	// Recommended start sequence, then a live count and status read
	task automatic run(input ttmr_mode_type m, input logic [27:0] st,
		input logic [27:0] rf, input int n);
		logic [27:0] c;
		logic p;
		logic h;
		wr(`TTMR_OFF_CTRL, 32'h00000000);
		wr(`TTMR_OFF_STAT, 32'h00000001);
		wr(`TTMR_OFF_COUNT, {4'h0, st});
		wr(`TTMR_OFF_REF, {4'h0, rf});
		wr(`TTMR_OFF_CTRL, {30'h0, m});
		repeat (n) @(posedge clk_sys);
		model(m, st, rf, n + 1, c, p, h);
		rd(`TTMR_OFF_COUNT, {4'h0, c});
		model(m, st, rf, n + 4, c, p, h);
		rd(`TTMR_OFF_STAT, {30'h0, h, p});
	endtask : run

	task automatic tally_and_finish();
		$display("compares %0d errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish

	// Read data is judged at the edge that ends its data phase
	always @(posedge clk_sys) begin
		if (rdPhase === 1'b1 && hreadyout === 1'b1) begin
			check(hrdata, expQ.pop_front());
			check_bit(hresp, 1'b0);
		end
	end

	initial begin
		repeat (6000) @(posedge clk_sys);
		num_errors++;
		tally_and_finish();
	end

	initial begin
		{hsel, hwrite, rdPhase, rst_b} = 4'h0;
		{haddr, hwdata, htrans, hsize} = 69'h0;
		num_errors = 0;
		compares = 0;
		seedVal = $urandom(93);
		repeat (8) @(posedge clk_sys);
		rst_b <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rd(`TTMR_OFF_CTRL, 32'h00000000);
		rd(`TTMR_OFF_STAT, 32'h00000000);
		repeat (20) @(posedge clk_sys);
		rd(`TTMR_OFF_COUNT, 32'h00000000);
		check_bit(tickIrq, 1'b0);
		$display("test reset done");
		r = 28'($urandom());
		wr(`TTMR_OFF_REF, {4'hF, r});
		rd(`TTMR_OFF_REF, {4'h0, r});
		bus(1'b1, `TTMR_OFF_REF, {4'h0, ~r}, 3'h0);
		rd(`TTMR_OFF_REF, {4'h0, r});
		wr(12'h010, {4'h0, r});
		rd(12'h010, 32'h00000000);
		$display("test registers done");
		for (int i = 1; i < 4; i++) begin
			repeat (4) begin
				s = 28'($urandom());
				r = s + 28'($urandom() % 12);
				run(ttmr_mode_type'(i), s, r, $urandom() % 30);
			end
		end
		run(MODE_CONTINUE_ON_MATCH, 28'hFFFFFFE, 28'h0000002, 6);
		run(MODE_RESTART_ON_MATCH, 28'h0000000, 28'h0000004, 17);
		check_bit(tickIrq, 1'b0);
		$display("test modes done");
		run(MODE_SINGLE_SHOT, 28'h0000000, 28'h0000003, 10);
		wr(`TTMR_OFF_CTRL, 32'h00000004);
		repeat (2) @(posedge clk_sys);
		check_bit(tickIrq, 1'b1);
		check_bit(dozeWake, 1'b1);
		wr(`TTMR_OFF_STAT, 32'h00000001);
		repeat (2) @(posedge clk_sys);
		check_bit(tickIrq, 1'b0);
		rd(`TTMR_OFF_STAT, 32'h00000000);
		wr(`TTMR_OFF_CTRL, {29'h0, 1'b1, MODE_SINGLE_SHOT});
		repeat (3) @(posedge clk_sys);
		check_bit(tickIrq, 1'b1);
		rd(`TTMR_OFF_COUNT, 32'h00000003);
		wr(`TTMR_OFF_COUNT, 32'h00000005);
		rd(`TTMR_OFF_COUNT, 32'h00000006);
		wr(`TTMR_OFF_COUNT, 32'h00000000);
		rd(`TTMR_OFF_COUNT, 32'h00000001);
		wr(`TTMR_OFF_CTRL, 32'h00000000);
		wr(`TTMR_OFF_COUNT, 32'h00000009);
		wr(`TTMR_OFF_COUNT, 32'h00000000);
		rd(`TTMR_OFF_COUNT, 32'h00000000);
		$display("test single shot done");
		@(posedge clk_sys);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
